// ---- src/rtcisp_pkg.sv ----
// Constants, register map and carrier types of the RTC interrupt, status and power block
//
// What this block does
// - Pending flag when any flag meets enable
// - Interrupt pin low exactly while pending
// - Flag read or host reset clears flags
// - Periodic flag set regardless of enable
// - Alarm flag set on alarm time match
// - Update-ended flag set after each update
// - Flag low nibble reads zero, unwritable
// - Valid bit set only by reading it
// - General bytes stay usable during updates
// - Read snapshot stable, late events kept
// - Late enable of set flag interrupts immediately
// - Wake control: bits 2,0, zero at POR
// - Missed second alarm wakes on standby return
// - Standby return wakes when wake enabled
// - 22 stage divider yields 1 Hz update
// - First update half second after hold
// - Periodic rate 500 ms to 122 us
// - Supply low blocks all host modification
// - Lockout lasts 62 to 125 ms
// - Skip lockout unless normal and valid
// - Oscillator stops on disabled divider codes
// - Fresh battery: stop oscillator, zero registers
// - Low battery clears only the valid bit
// - Enables at bits 6-4, reset clears
// - Divider control code meanings
// - Rate field: off or fifteen codes over thirteen taps
package rtcisp_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ              = 50_000_000;
  localparam int unsigned CLK_KHZ             = 50_000;
  localparam int unsigned CHAIN_HZ            = 4_194_304;
  localparam int unsigned LOCKOUT_MIN_MS      = 62;
  localparam int unsigned LOCKOUT_MAX_MS      = 125;
  localparam int unsigned LOCKOUT_CYCLES_DFLT = LOCKOUT_MIN_MS * CLK_KHZ;
  localparam int          LK_CNT_W            = 23;
  localparam int          ACC_W               = 26;
  localparam logic [ACC_W:0] ACC_INC          = (ACC_W+1)'(CHAIN_HZ);
  localparam logic [ACC_W:0] ACC_WRAP         = (ACC_W+1)'(CLK_HZ);
  localparam int          DIV_STAGES          = 22;
  localparam int          UPD_BIT             = 21;
  localparam int          RS_TAP_BASE         = 5;
  localparam int          TAP_RS1             = 13;
  localparam int          TAP_RS2             = 14;

  // ****************************************************************
  // Register map (index; byte address is four times the index)
  // ****************************************************************
  localparam int          IDX_W        = 9;
  localparam int          ADDR_LSB     = 2;
  localparam logic [2:0]  SIZE_WORD    = 3'h2;
  localparam logic [IDX_W-1:0] IDX_CTRL_A   = 9'h00A;
  localparam logic [IDX_W-1:0] IDX_CTRL_B   = 9'h00B;
  localparam logic [IDX_W-1:0] IDX_FLAGS    = 9'h00C;
  localparam logic [IDX_W-1:0] IDX_VALID    = 9'h00D;
  localparam logic [IDX_W-1:0] IDX_GP_FIRST = 9'h00E;
  localparam logic [IDX_W-1:0] IDX_GP_LAST  = 9'h0FF;
  localparam logic [IDX_W-1:0] IDX_WAKE     = 9'h100;

  // ****************************************************************
  // Field positions and codes
  // ****************************************************************
  localparam int A_DV_LSB = 4;
  localparam int A_RS_LSB = 0;
  localparam int B_SET    = 7;
  localparam int B_PIE    = 6;
  localparam int B_AIE    = 5;
  localparam int B_UIE    = 4;
  localparam int B_DM     = 2;
  localparam int B_H24    = 1;
  localparam int C_IRQ_PENDING_FLAG   = 7;
  localparam int D_VRT    = 7;
  localparam int W_POR    = 2;
  localparam int W_AL2    = 0;
  localparam logic [2:0] DV_NORMAL  = 3'h2;
  localparam logic [2:0] DV_RST     = 3'h0;
  localparam logic [1:0] DV_OFF_HI  = 2'h0;
  localparam logic [1:0] DV_HOLD_HI = 2'h3;
  localparam logic [3:0] RS_OFF     = 4'h0;
  localparam logic [3:0] RS_1       = 4'h1;
  localparam logic [3:0] RS_2       = 4'h2;
  localparam logic [3:0] RS_RST     = 4'h0;
  // Flag vector order inside the state: periodic, alarm, update-ended
  localparam int F_PF = 2;
  localparam int F_AF = 1;
  localparam int F_UF = 0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic host_reset_in;
    logic supply_low;
    logic standby_supply;
    logic battery_fresh;
    logic battery_low;
  } rtcisp_supply_t;

  typedef enum logic [2:0] {LK_OPEN = 3'b001, LK_LOW = 3'b010, LK_HOLD = 3'b100} rtcisp_lk_t;
  typedef enum logic [1:0] {PW_IDLE = 2'b01, PW_REQ = 2'b10} rtcisp_pw_t;

  typedef struct packed {
    rtcisp_supply_t          sync1;
    rtcisp_supply_t          sync2;
    logic                    low_prev;
    logic                    sb_prev;
    logic [ACC_W-1:0]        acc;
    logic [DIV_STAGES-1:0]   div;
    logic [2:0]              dv;
    logic [3:0]              rs;
    logic                    set_b;
    logic                    periodic_irq_enable;
    logic                    alarm_irq_enable;
    logic                    update_irq_enable;
    logic                    dm;
    logic                    h24;
    logic [2:0]              flags;
    logic                    valid;
    logic                    wake_por;
    logic                    wake_al2;
    logic                    al2_missed;
    rtcisp_lk_t              lk_state;
    logic [LK_CNT_W-1:0]     lk_cnt;
    rtcisp_pw_t              pw_state;
    logic                    wr_pend;
    logic [IDX_W-1:0]        wr_idx;
    logic [31:0]             hrdata;
    logic                    irq_n;
    logic                    lockout;
    logic                    pwr_n;
    logic                    ready;
  } rtcisp_state_t;

  localparam rtcisp_state_t ST_RST = '{
    lk_state: LK_OPEN, pw_state: PW_IDLE, dv: DV_RST, rs: RS_RST,
    irq_n: 1'b1, pwr_n: 1'b1, ready: 1'b1, default: '0};

endpackage : rtcisp_pkg

// ---- src/rtcisp_top.sv ----
// RTC interrupt flags, valid status, wake control, divider and supply lockout behind AHB-Lite
`timescale 1ns/1ps
module rtcisp_top #(
  parameter int unsigned LOCKOUT_CYCLES = rtcisp_pkg::LOCKOUT_CYCLES_DFLT
) (
  input  wire logic                       hclk,
  input  wire logic                       hresetn,
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic      [31:0]                hrdata,
  output logic                            hreadyout,
  output logic                            hresp,
  input  wire rtcisp_pkg::rtcisp_supply_t supply_pins,
  input  wire logic                       alarm_match,
  input  wire logic                       alarm2_match,
  output logic                            rtc_irq_n,
  output logic                            power_on_request_n,
  output logic                            bus_write_lockout
);
  import rtcisp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rtcisp_state_t         st_reg;
  rtcisp_state_t         st_next;
  logic [7:0]            gp_ram [IDX_GP_FIRST:IDX_GP_LAST];
  logic [IDX_W-1:0]      a_idx;
  logic                  addr_ok;
  logic                  acc_rd;
  logic                  acc_wr;
  logic                  locked;
  logic                  hr_act;
  logic                  osc_run;
  logic                  div_hold;
  logic                  tick;
  logic                  per_evt;
  logic                  upd_evt;
  logic                  lk_fall;
  logic                  lock_cond;
  logic                  sb_rise;
  logic                  wr_ok;
  logic                  pending_q;
  logic [ACC_W:0]        acc_sum;
  logic [DIV_STAGES-1:0] tap_mask;
  logic [2:0]            clr_bits;
  logic [2:0]            set_bits;
  logic [7:0]            rd_byte;

  // Mask of divider bits up to the selected tap; the tap falls when all are ones
  function automatic logic [DIV_STAGES-1:0] tap_of(input logic [3:0] rs);
    logic [DIV_STAGES-1:0] m;
    int                    k;
    m = '0;
    if (rs == RS_1) begin
      k = TAP_RS1;
    end else if (rs == RS_2) begin
      k = TAP_RS2;
    end else begin
      k = RS_TAP_BASE + int'(rs);
    end
    for (int i = 0; i < DIV_STAGES; i++) begin
      m[i] = (i <= k);
    end
    return m;
  endfunction : tap_of

  // ****************************************************************
  // Bus decode and time base
  // ****************************************************************
  assign a_idx     = haddr[ADDR_LSB +: IDX_W];
  assign addr_ok   = (haddr[31:ADDR_LSB+IDX_W] == '0) && (hsize == SIZE_WORD);
  assign acc_rd    = hsel && htrans[1] && hready && !hwrite && addr_ok;
  assign acc_wr    = hsel && htrans[1] && hready && hwrite && addr_ok;
  assign locked    = (st_reg.lk_state != LK_OPEN);
  assign hr_act    = st_reg.sync2.host_reset_in && !locked;
  assign wr_ok     = st_reg.wr_pend && !locked;
  // Fresh battery with main supply absent keeps the oscillator off
  assign osc_run   = (st_reg.dv[2:1] != DV_OFF_HI)
                     && !(st_reg.sync2.battery_fresh && st_reg.sync2.supply_low);
  assign div_hold  = (st_reg.dv[2:1] == DV_HOLD_HI);
  // Phase accumulator gives an exact average chain rate from the bus clock
  assign acc_sum   = {1'b0, st_reg.acc} + ACC_INC;
  assign tick      = osc_run && (acc_sum >= ACC_WRAP);
  assign tap_mask  = tap_of(st_reg.rs);
  assign per_evt   = tick && !div_hold && (st_reg.rs != RS_OFF)
                     && (&(st_reg.div | ~tap_mask));
  // Rising edge of the last stage: 2^21 chain ticks after the hold is lifted
  assign upd_evt   = tick && !div_hold && !st_reg.set_b
                     && (&st_reg.div[UPD_BIT-1:0]) && !st_reg.div[UPD_BIT];
  assign lk_fall   = st_reg.low_prev && !st_reg.sync2.supply_low;
  assign lock_cond = (st_reg.dv == DV_NORMAL) && st_reg.valid
                     && !st_reg.sync2.battery_fresh && !st_reg.sync2.battery_low;
  assign sb_rise   = st_reg.sync2.standby_supply && !st_reg.sb_prev;
  assign pending_q = |(st_reg.flags & {st_reg.periodic_irq_enable, st_reg.alarm_irq_enable, st_reg.update_irq_enable});

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    rd_byte = '0;
    if (a_idx == IDX_CTRL_A) begin
      rd_byte[A_DV_LSB +: 3] = st_reg.dv;
      rd_byte[A_RS_LSB +: 4] = st_reg.rs;
    end else if (a_idx == IDX_CTRL_B) begin
      rd_byte[B_SET] = st_reg.set_b;
      rd_byte[B_PIE] = st_reg.periodic_irq_enable;
      rd_byte[B_AIE] = st_reg.alarm_irq_enable;
      rd_byte[B_UIE] = st_reg.update_irq_enable;
      rd_byte[B_DM]  = st_reg.dm;
      rd_byte[B_H24] = st_reg.h24;
    end else if (a_idx == IDX_FLAGS) begin
      // Low nibble stays zero
      rd_byte[C_IRQ_PENDING_FLAG]       = pending_q;
      rd_byte[C_IRQ_PENDING_FLAG-1 -: 3] = st_reg.flags;
    end else if (a_idx == IDX_VALID) begin
      rd_byte[D_VRT] = st_reg.valid;
    end else if (a_idx >= IDX_GP_FIRST && a_idx <= IDX_GP_LAST) begin
      rd_byte = gp_ram[a_idx];
    end else if (a_idx == IDX_WAKE) begin
      rd_byte[W_POR] = st_reg.wake_por;
      rd_byte[W_AL2] = st_reg.wake_al2;
    end
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_next          = st_reg;
    st_next.sync1    = supply_pins;
    st_next.sync2    = st_reg.sync1;
    st_next.low_prev = st_reg.sync2.supply_low;
    st_next.sb_prev  = st_reg.sync2.standby_supply;
    st_next.ready    = 1'b1;
    st_next.wr_pend  = acc_wr;
    st_next.wr_idx   = a_idx;

    // Divider chain
    if (osc_run) begin
      st_next.acc = tick ? ACC_W'(acc_sum - ACC_WRAP) : acc_sum[ACC_W-1:0];
    end
    if (div_hold) begin
      st_next.div = '0;
    end else if (tick) begin
      st_next.div = st_reg.div + DIV_STAGES'(1);
    end

    // Register writes in the data phase
    if (wr_ok) begin
      case (st_reg.wr_idx)
        IDX_CTRL_A: begin
          st_next.dv = hwdata[A_DV_LSB +: 3];
          st_next.rs = hwdata[A_RS_LSB +: 4];
        end
        IDX_CTRL_B: begin
          st_next.set_b = hwdata[B_SET];
          st_next.periodic_irq_enable   = hwdata[B_PIE];
          st_next.alarm_irq_enable   = hwdata[B_AIE];
          // SET rising forces the update enable off
          st_next.update_irq_enable   = hwdata[B_UIE] && !(hwdata[B_SET] && !st_reg.set_b);
          st_next.dm    = hwdata[B_DM];
          st_next.h24   = hwdata[B_H24];
        end
        IDX_WAKE: begin
          st_next.wake_por = hwdata[W_POR];
          st_next.wake_al2 = hwdata[W_AL2];
        end
        default: begin
        end
      endcase
    end
    if (hr_act) begin
      st_next.periodic_irq_enable = 1'b0;
      st_next.alarm_irq_enable = 1'b0;
      st_next.update_irq_enable = 1'b0;
    end

    // Flags: the read snapshot clears only what it returned; new events win
    clr_bits = (acc_rd && a_idx == IDX_FLAGS && !locked) ? st_reg.flags : '0;
    set_bits = '0;
    set_bits[F_PF] = per_evt;
    set_bits[F_AF] = alarm_match;
    set_bits[F_UF] = upd_evt;
    st_next.flags = (st_reg.flags & ~(clr_bits | {3{hr_act}})) | set_bits;

    // Valid bit is set only by reading it
    if (acc_rd && a_idx == IDX_VALID && !locked) begin
      st_next.valid = 1'b1;
    end

    // Battery checks when main supply returns
    if (lk_fall && st_reg.sync2.battery_fresh) begin
      st_next.dv    = DV_RST;
      st_next.rs    = RS_RST;
      st_next.set_b = 1'b0;
      st_next.periodic_irq_enable   = 1'b0;
      st_next.alarm_irq_enable   = 1'b0;
      st_next.update_irq_enable   = 1'b0;
      st_next.dm    = 1'b0;
      st_next.h24   = 1'b0;
      st_next.flags = '0;
      st_next.valid = 1'b0;
    end else if (lk_fall && st_reg.sync2.battery_low) begin
      st_next.valid = 1'b0;
    end

    // Supply lockout
    case (st_reg.lk_state)
      LK_OPEN: begin
        if (st_reg.sync2.supply_low) begin
          st_next.lk_state = LK_LOW;
        end
      end
      LK_LOW: begin
        if (!st_reg.sync2.supply_low) begin
          if (lock_cond) begin
            st_next.lk_state = LK_HOLD;
            st_next.lk_cnt   = LK_CNT_W'(LOCKOUT_CYCLES - 1);
          end else begin
            st_next.lk_state = LK_OPEN;
          end
        end
      end
      LK_HOLD: begin
        if (st_reg.sync2.supply_low) begin
          st_next.lk_state = LK_LOW;
        end else if (st_reg.lk_cnt == '0) begin
          st_next.lk_state = LK_OPEN;
        end else begin
          st_next.lk_cnt = st_reg.lk_cnt - LK_CNT_W'(1);
        end
      end
      default: begin
        st_next.lk_state = LK_LOW;
      end
    endcase

    // Wake requests; a missed second alarm is remembered until standby returns
    st_next.al2_missed = (st_reg.al2_missed && !sb_rise)
                         || (alarm2_match && !st_reg.sync2.standby_supply && st_reg.wake_al2);
    case (st_reg.pw_state)
      PW_IDLE: begin
        if (sb_rise && (st_reg.wake_por || (st_reg.wake_al2 && st_reg.al2_missed))) begin
          st_next.pw_state = PW_REQ;
        end
      end
      PW_REQ: begin
        // Main supply up ends the request
        if (!st_reg.sync2.supply_low) begin
          st_next.pw_state = PW_IDLE;
        end
      end
      default: begin
        st_next.pw_state = PW_IDLE;
      end
    endcase

    // Registered outputs track the next state so pin and flags never disagree
    if (acc_rd) begin
      st_next.hrdata = {24'h000000, rd_byte};
    end
    st_next.irq_n   = !(|(st_next.flags & {st_next.periodic_irq_enable, st_next.alarm_irq_enable, st_next.update_irq_enable}));
    st_next.lockout = (st_next.lk_state != LK_OPEN);
    st_next.pwr_n   = (st_next.pw_state != PW_REQ);
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // General bytes ignore the update cycle; only the supply lockout blocks them
  always_ff @(posedge hclk) begin
    if (wr_ok && st_reg.wr_idx >= IDX_GP_FIRST && st_reg.wr_idx <= IDX_GP_LAST) begin
      gp_ram[st_reg.wr_idx] <= hwdata[7:0];
    end
  end

  assign hrdata             = st_reg.hrdata;
  assign hreadyout          = st_reg.ready;
  assign hresp              = 1'b0;
  assign rtc_irq_n          = st_reg.irq_n;
  assign power_on_request_n = st_reg.pwr_n;
  assign bus_write_lockout  = st_reg.lockout;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rd_flags_pf;
    acc_rd && a_idx == IDX_FLAGS && !locked && st_reg.flags[F_PF] && !per_evt && !hr_act;
  endsequence
  sequence s_late_enable;
    (st_reg.flags[F_AF] && !st_reg.alarm_irq_enable) ##1 (st_reg.alarm_irq_enable && st_reg.flags[F_AF]);
  endsequence
  sequence s_restore_lock;
    lk_fall && st_reg.lk_state == LK_LOW && lock_cond;
  endsequence

  property p_irq_pin;
    rtc_irq_n == !pending_q;
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("irq pin disagrees with pending");

  property p_late_enable;
    s_late_enable |-> !rtc_irq_n;
  endproperty
  a_late_enable: assert property (p_late_enable) else $error("late enable no irq");

  property p_read_clear;
    s_rd_flags_pf |=> (!st_reg.flags[F_PF] && hrdata[C_IRQ_PENDING_FLAG-1]);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flag read did not clear");

  property p_low_nibble;
    (acc_rd && a_idx == IDX_FLAGS) |=> (hrdata[3:0] == 4'h0);
  endproperty
  a_low_nibble: assert property (p_low_nibble) else $error("flag low nibble not zero");

  property p_periodic;
    per_evt |=> st_reg.flags[F_PF];
  endproperty
  a_periodic: assert property (p_periodic) else $error("periodic flag not set");

  property p_alarm;
    (alarm_match && !(lk_fall && st_reg.sync2.battery_fresh)) |=> st_reg.flags[F_AF];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag not set");

  property p_update;
    (upd_evt && !(lk_fall && st_reg.sync2.battery_fresh)) |=> st_reg.flags[F_UF];
  endproperty
  a_update: assert property (p_update) else $error("update flag not set");

  property p_valid_read;
    (acc_rd && a_idx == IDX_VALID && !locked && !lk_fall) |=> st_reg.valid;
  endproperty
  a_valid_read: assert property (p_valid_read) else $error("valid not set by read");

  property p_uie_on_set;
    (wr_ok && st_reg.wr_idx == IDX_CTRL_B && hwdata[B_SET] && !st_reg.set_b) |=> !st_reg.update_irq_enable;
  endproperty
  a_uie_on_set: assert property (p_uie_on_set) else $error("update enable kept on set");

  property p_hold_div;
    div_hold |=> (st_reg.div == '0);
  endproperty
  a_hold_div: assert property (p_hold_div) else $error("divider not held");

  property p_osc_off;
    (!osc_run && !wr_ok) |=> ($stable(st_reg.acc) && $stable(st_reg.div));
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("chain ran while stopped");

  property p_lock_start;
    s_restore_lock |=> (st_reg.lk_state == LK_HOLD && bus_write_lockout);
  endproperty
  a_lock_start: assert property (p_lock_start) else $error("lockout not started");

  property p_lock_skip;
    (lk_fall && st_reg.lk_state == LK_LOW && !lock_cond) |=> !bus_write_lockout;
  endproperty
  a_lock_skip: assert property (p_lock_skip) else $error("lockout not skipped");

  property p_write_blocked;
    (locked && st_reg.wr_pend && st_reg.wr_idx == IDX_CTRL_A && !lk_fall) |=> $stable(st_reg.dv);
  endproperty
  a_write_blocked: assert property (p_write_blocked) else $error("write during lockout");

  property p_wake;
    (sb_rise && st_reg.wake_por && st_reg.pw_state == PW_IDLE) |=> !power_on_request_n;
  endproperty
  a_wake: assert property (p_wake) else $error("standby wake missing");

endmodule : rtcisp_top

// ---- dv/rtcisp_host.sv ----
// AHB-Lite host model issuing single word transfers
`timescale 1ns/1ps
module rtcisp_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  logic [31:0] rd_q;
  initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
  // Waits on hready in both phases; only the bench watchdog ends a hang
  task xfer(input logic w, input logic [8:0] i, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {21'h0, i, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_q = hrdata;
  endtask : xfer
endmodule : rtcisp_host

// ---- dv/tb.sv ----
// Self-checking bench for the RTC interrupt, status and power block
`timescale 1ns/1ps
module tb;
  import rtcisp_pkg::*;
  logic           hclk, hresetn, hsel, hwrite, hreadyout, alarm_match, alarm2_match;
  logic           rtc_irq_n, power_on_request_n, bus_write_lockout, hresp;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [31:0]    haddr, hwdata, hrdata, d;
  rtcisp_supply_t supply_pins;
  int             fail_count, n_tests, seed;
  rtcisp_top #(.LOCKOUT_CYCLES(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .supply_pins(supply_pins), .alarm_match(alarm_match), .alarm2_match(alarm2_match),
    .rtc_irq_n(rtc_irq_n), .power_on_request_n(power_on_request_n),
    .bus_write_lockout(bus_write_lockout));
  rtcisp_host host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task rd(input logic [8:0] i, input logic [31:0] e);
    host_u.xfer(1'b0, i, 32'h0);
    chk("register", e, host_u.rd_q);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : rd
  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  function automatic logic [31:0] flg(input logic [2:0] f, input logic [2:0] en);
    return {24'h0, |(f & en), f, 4'h0};
  endfunction : flg
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    repeat (40000) @(posedge hclk);
    fail_count++;
    give_verdict;
  end
  initial begin
    {hresetn, alarm_match, alarm2_match} = 3'h0;
    supply_pins = '0;
    seed = 18761;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(IDX_FLAGS, 32'h0);
    rd(IDX_VALID, 32'h0);
    rd(IDX_VALID, 32'h80);
    rd(IDX_WAKE, 32'h0);
    $display("reset test done");
    @(posedge hclk);
    alarm_match <= 1'b1;
    @(posedge hclk);
    alarm_match <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("irq_n", 32'h1, {31'h0, rtc_irq_n});
    host_u.xfer(1'b1, IDX_CTRL_B, 32'h20);
    repeat (2) @(posedge hclk);
    chk("irq_n", 32'h0, {31'h0, rtc_irq_n});
    rd(IDX_FLAGS, flg(3'b010, 3'b010));
    @(posedge hclk);
    chk("irq_n", 32'h1, {31'h0, rtc_irq_n});
    host_u.xfer(1'b1, IDX_FLAGS, 32'hFF);
    rd(IDX_FLAGS, 32'h0);
    $display("alarm test done");
    // Index kept below the wake register so random bytes stay in the general area
    repeat (4) begin
      d = $random(seed);
      host_u.xfer(1'b1, IDX_GP_FIRST + 9'(d[14:8]), d);
      rd(IDX_GP_FIRST + 9'(d[14:8]), {24'h0, d[7:0]});
    end
    host_u.xfer(1'b1, IDX_WAKE, 32'hFF);
    rd(IDX_WAKE, 32'h05);
    host_u.xfer(1'b1, IDX_GP_FIRST, 32'h11);
    supply_pins.supply_low <= 1'b1;
    repeat (5) @(posedge hclk);
    chk("lockout", 32'h1, {31'h0, bus_write_lockout});
    host_u.xfer(1'b1, IDX_GP_FIRST, 32'h22);
    supply_pins.standby_supply <= 1'b1;
    repeat (5) @(posedge hclk);
    chk("power_n", 32'h0, {31'h0, power_on_request_n});
    supply_pins.supply_low <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("lockout", 32'h0, {31'h0, bus_write_lockout});
    rd(IDX_GP_FIRST, 32'h11);
    $display("supply test done");
    host_u.xfer(1'b1, IDX_CTRL_A, 32'h23);
    repeat (13000) @(posedge hclk);
    rd(IDX_FLAGS, flg(3'b100, 3'b010));
    $display("periodic test done");
    // Divider normal and time valid, so the restore hold must run its full count
    supply_pins.supply_low <= 1'b1;
    repeat (5) @(posedge hclk);
    host_u.xfer(1'b1, IDX_CTRL_A, 32'h60);
    supply_pins.supply_low <= 1'b0;
    repeat (6) @(posedge hclk);
    chk("lockout", 32'h1, {31'h0, bus_write_lockout});
    repeat (8) @(posedge hclk);
    chk("lockout", 32'h0, {31'h0, bus_write_lockout});
    rd(IDX_CTRL_A, 32'h23);
    $display("restore hold test done");
    host_u.xfer(1'b1, IDX_CTRL_A, 32'h20);
    host_u.xfer(1'b1, IDX_CTRL_B, 32'h70);
    supply_pins.host_reset_in <= 1'b1;
    repeat (4) @(posedge hclk);
    supply_pins.host_reset_in <= 1'b0;
    repeat (3) @(posedge hclk);
    rd(IDX_CTRL_B, 32'h0);
    rd(IDX_FLAGS, 32'h0);
    $display("reset pin test done");
    supply_pins.battery_low <= 1'b1;
    supply_pins.supply_low  <= 1'b1;
    repeat (5) @(posedge hclk);
    supply_pins.supply_low  <= 1'b0;
    repeat (5) @(posedge hclk);
    rd(IDX_VALID, 32'h0);
    rd(IDX_CTRL_A, 32'h20);
    $display("low battery test done");
    give_verdict;
  end
endmodule : tb
